/* shared/clh_pkg.sv */
// package for the character display host port: timing, layout, encodings
// assumes a single 25 MHz clock for the whole block
package clh_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS   = 40;
  localparam int BUSY_NS  = 40000;
  localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int POR_NS   = 100000;
  localparam int POR_CYC  = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int OSC_DIV  = 100;

  // ----------------------------------------------------------------
  // display layout
  // ----------------------------------------------------------------
  localparam int SEG_N    = 40;
  localparam int COM_N    = 16;
  localparam int CHAR_W   = 5;
  localparam int CHARS    = 2 * SEG_N / CHAR_W;
  localparam int DD_DEPTH = 80;
  localparam int CG_DEPTH = 64;
  localparam logic [6:0]  DD_SIZE      = 7'h50;
  localparam logic [6:0]  LINE1_START  = 7'h00;
  localparam logic [6:0]  LINE2_START  = 7'h28;
  localparam logic [3:0]  CG_CODE_HI   = 4'h0;
  localparam logic [6:0]  SHIFT_PHASES = 7'h50;
  localparam logic [6:0]  PH_LAST      = 7'h51;
  localparam logic [15:0] COM_FIRST    = 16'h0001;
  localparam logic [3:0]  LAST_COM_8   = 4'h7;
  localparam logic [3:0]  LAST_COM_11  = 4'ha;
  localparam logic [3:0]  LAST_COM_16  = 4'hf;

  // ----------------------------------------------------------------
  // command encoding
  // ----------------------------------------------------------------
  localparam int CMD_DDADDR_BIT = 7;
  localparam int CMD_CGADDR_BIT = 6;
  localparam int CMD_FUNC_BIT   = 5;
  localparam int CMD_ENTRY_BIT  = 2;
  localparam int FUNC_DL_BIT    = 4;
  localparam int FUNC_N_BIT     = 3;
  localparam int FUNC_F_BIT     = 2;
  localparam int ENTRY_ID_BIT   = 1;

  typedef enum logic [1:0] {
    CLH_DUTY_8  = 2'b00,
    CLH_DUTY_11 = 2'b01,
    CLH_DUTY_16 = 2'b11
  } clh_duty_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_STEP  = 2'b01,
    ST_FETCH = 2'b11,
    ST_WAIT  = 2'b10
  } clh_op_t;

endpackage

/* src/clh_scan_gen.sv */
// scan timing: dot clock source, common scan, extension driver stream
// assumes row data for the current common arrives combinationally
`timescale 1ns/100ps
module clh_scan_gen #(
  parameter int OSC_DIVIDE = clh_pkg::OSC_DIV
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             resistor_fitted_in,
  input  wire logic             oscillator_input_in,
  input  wire clh_pkg::clh_duty_t duty_in,
  input  wire logic [39:0]      seg_row_in,
  input  wire logic [39:0]      ext_row_in,
  output logic      [3:0]       row_out,
  output logic      [39:0]      segment_out,
  output logic      [15:0]      common_out,
  output logic                  ext_latch_clock_out,
  output logic                  ext_shift_clock_out,
  output logic                  alt_signal_out,
  output logic                  ext_data_out
);
  import clh_pkg::*;
  localparam int DIV_W = $clog2(OSC_DIVIDE + 1);

  logic [DIV_W-1:0] div_q, div_d;
  logic             osc_q, tick_w;
  logic [6:0]       ph_q, ph_d;
  logic [3:0]       com_q, com_d, last_com_w;
  logic [39:0]      seg_q, seg_d;
  logic [15:0]      cout_q, cout_d;
  logic             lat_q, lat_d, sh_q, sh_d, alt_q, alt_d, dat_q, dat_d;

  // ----------------------------------------------------------------
  // dot clock source
  // ----------------------------------------------------------------
  // no resistor means the oscillator pin carries the clock itself
  // clock source select
  assign tick_w = resistor_fitted_in ? (div_q == '0)
                                     : (oscillator_input_in & ~osc_q);

  always_comb begin
    case (duty_in)
      CLH_DUTY_8:  last_com_w = LAST_COM_8;
      CLH_DUTY_11: last_com_w = LAST_COM_11;
      default:     last_com_w = LAST_COM_16;
    endcase
  end

  // ----------------------------------------------------------------
  // scan sequencer
  // ----------------------------------------------------------------
  always_comb begin
    div_d  = (div_q == '0) ? DIV_W'(OSC_DIVIDE - 1) : div_q - 1'b1;
    ph_d   = ph_q;
    com_d  = com_q;
    seg_d  = seg_q;
    cout_d = cout_q;
    lat_d  = lat_q;
    sh_d   = sh_q;
    alt_d  = alt_q;
    dat_d  = dat_q;
    if (tick_w) begin
      ph_d = (ph_q == PH_LAST) ? '0 : ph_q + 1'b1;
      if (ph_q < SHIFT_PHASES) begin
        sh_d  = ph_q[0];
        dat_d = ext_row_in[ph_q[6:1]];
      end else if (ph_q == SHIFT_PHASES) begin
        sh_d  = 1'b0;
        lat_d = 1'b1;
      end else begin
        lat_d  = 1'b0;
        seg_d  = seg_row_in;
        cout_d = COM_FIRST << com_q;
        if (com_q >= last_com_w) begin
          com_d = '0;
          alt_d = ~alt_q;
        end else begin
          com_d = com_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q  <= '0;
      osc_q  <= 1'b0;
      ph_q   <= '0;
      com_q  <= '0;
      seg_q  <= '0;
      cout_q <= '0;
      lat_q  <= 1'b0;
      sh_q   <= 1'b0;
      alt_q  <= 1'b0;
      dat_q  <= 1'b0;
    end else begin
      div_q  <= div_d;
      osc_q  <= oscillator_input_in;
      ph_q   <= ph_d;
      com_q  <= com_d;
      seg_q  <= seg_d;
      cout_q <= cout_d;
      lat_q  <= lat_d;
      sh_q   <= sh_d;
      alt_q  <= alt_d;
      dat_q  <= dat_d;
    end
  end

  assign row_out             = com_q;
  assign segment_out         = seg_q;
  assign common_out          = cout_q;
  assign ext_latch_clock_out = lat_q;
  assign ext_shift_clock_out = sh_q;
  assign alt_signal_out      = alt_q;
  assign ext_data_out        = dat_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_latch_no_shift:
    assert property (lat_q |-> !sh_q)
    else $error("latch and shift clocks high together");
  chk_alt_frame_flip:
    assert property (tick_w && ph_q == PH_LAST && com_q >= last_com_w
                     |=> alt_q != $past(alt_q) && com_q == '0)
    else $error("alternating signal missed frame end");
  chk_duty_bound:
    assert property ($past(tick_w) && $past(ph_q) == PH_LAST
                     |-> com_q <= $past(last_com_w))
    else $error("common index beyond duty");
endmodule

/* src/clh_host_if.sv */
// host parallel port of a character display controller, with its RAMs
// assumes enable, select and direction inputs are synchronous to clk_in
//
// Operation
// - select high targets data register, low targets command register
// - direction high reads, low writes; pins driven only on reads
// - lower four pins carry low half in 8-bit mode, idle in 4-bit
// - 4-bit mode moves each byte as two transfers on upper pins
// - busy indication appears on the top data pin in status reads
// - data-length bit of a function command picks 4 or 8 bit width
// - two 8-bit holding registers: data and command
// - data traffic goes to whichever RAM was last addressed
// - after a data read the next RAM byte is prefetched
// - after a data write the byte is stored into the addressed RAM
// - command register is write-only; reads never return it
// - latch clock and shift clock drive the extension driver
// - dots from the 41st onward leave serially on one output
// - alternating polarity output removes DC from the panel
// - scan duty one in eight, eleven or sixteen
// - sixteen commons scanned, forty segments driven directly
// - display RAM holds eighty 8-bit character codes
// - internal oscillator with resistor, else external clock input
// - internal logic resets itself at power-up
// - while busy new commands are refused; host polls status first
// - address counter steps after access, readable on low seven pins
`timescale 1ns/100ps
module clh_host_if #(
  parameter int BUSY_CYCLES = clh_pkg::BUSY_CYC,
  parameter int POR_CYCLES  = clh_pkg::POR_CYC,
  parameter int OSC_DIVIDE  = clh_pkg::OSC_DIV
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        enable_strobe_in,
  input  wire logic        register_select_in,
  input  wire logic        read_select_in,
  input  wire logic [7:0]  host_data_pins_in,
  output logic      [7:0]  host_data_pins_out,
  output logic      [7:0]  host_data_pins_oe_out,
  input  wire logic        resistor_fitted_in,
  input  wire logic        oscillator_input_in,
  output logic      [39:0] segment_out,
  output logic      [15:0] common_out,
  output logic             ext_latch_clock_out,
  output logic             ext_shift_clock_out,
  output logic             alt_signal_out,
  output logic             ext_data_out
);
  import clh_pkg::*;
  localparam int MAXC  = (BUSY_CYCLES > POR_CYCLES) ? BUSY_CYCLES
                                                    : POR_CYCLES;
  localparam int CNT_W = $clog2(MAXC + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic             e_q, e_d, oe_q, oe_d, nib_q, nib_d;
  logic [7:0]       rd_q, rd_d;
  logic [3:0]       hi_q, hi_d;
  logic             four_bit_q, four_bit_d, two_line_q, two_line_d;
  logic             font_q, font_d, inc_q, inc_d, cg_sel_q, cg_sel_d;
  logic             op_wr_q, op_wr_d;
  logic [6:0]       ac_q, ac_d;
  logic [7:0]       dr_q, dr_d, cmd_q, cmd_d;
  clh_op_t          state_q, state_d;
  logic [CNT_W-1:0] busy_cnt_q, busy_cnt_d, por_cnt_q, por_cnt_d;

  logic [7:0]       dd_mem [DD_DEPTH];
  logic [7:0]       cg_mem [CG_DEPTH];

  logic             e_fall_w, e_rise_w, busy_w, byte_done_w, dd_ok_w;
  logic             mem_we_w;
  logic [7:0]       wr_byte_w, read_val_w, ram_rd_w;
  logic [6:0]       dd_idx_w, ac_step_w;

  // ----------------------------------------------------------------
  // strobe edges and byte assembly
  // ----------------------------------------------------------------
  // edges of the enable strobe
  assign e_fall_w = e_q & ~enable_strobe_in;
  assign e_rise_w = enable_strobe_in & ~e_q;
  assign busy_w   = (state_q != ST_IDLE) | (por_cnt_q != '0);
  assign byte_done_w = e_fall_w & (~four_bit_q | nib_q);
  assign wr_byte_w = four_bit_q ? {hi_q, host_data_pins_in[7:4]}
                                : host_data_pins_in;
  // status carries busy and counter, never the command code
  // command register not readable
  assign read_val_w = register_select_in ? dr_q : {busy_w, ac_q};

  // ----------------------------------------------------------------
  // RAM addressing
  // ----------------------------------------------------------------
  // two-line layout folds the second line onto entries 40..79
  // display RAM index
  assign dd_idx_w = (two_line_q && ac_q[6]) ? LINE2_START + {1'b0, ac_q[5:0]}
                                            : ac_q;
  assign dd_ok_w  = dd_idx_w < DD_SIZE;
  // target RAM from last address command
  assign ram_rd_w = cg_sel_q ? cg_mem[ac_q[5:0]]
                             : (dd_ok_w ? dd_mem[dd_idx_w] : '0);
  always_comb begin
    if (cg_sel_q) begin
      ac_step_w = {1'b0, inc_q ? ac_q[5:0] + 6'h01 : ac_q[5:0] - 6'h01};
    end else begin
      ac_step_w = inc_q ? ac_q + 7'h01 : ac_q - 7'h01;
    end
  end
  assign mem_we_w = (state_q == ST_STEP) & op_wr_q;

  // ----------------------------------------------------------------
  // host transfer and internal operation
  // ----------------------------------------------------------------
  always_comb begin
    e_d        = enable_strobe_in;
    oe_d       = oe_q;
    nib_d      = nib_q;
    rd_d       = rd_q;
    hi_d       = hi_q;
    four_bit_d = four_bit_q;
    two_line_d = two_line_q;
    font_d     = font_q;
    inc_d      = inc_q;
    cg_sel_d   = cg_sel_q;
    op_wr_d    = op_wr_q;
    ac_d       = ac_q;
    dr_d       = dr_q;
    cmd_d      = cmd_q;
    state_d    = state_q;
    busy_cnt_d = (busy_cnt_q != '0) ? busy_cnt_q - 1'b1 : busy_cnt_q;
    por_cnt_d  = (por_cnt_q != '0) ? por_cnt_q - 1'b1 : por_cnt_q;
    // drive only while a read strobe is up
    if (e_rise_w && read_select_in) begin
      oe_d = 1'b1;
      if (!four_bit_q) begin
        rd_d = read_val_w;
      end else if (!nib_q) begin
        rd_d = {read_val_w[7:4], 4'h0};
      end else begin
        rd_d = {read_val_w[3:0], 4'h0};
      end
    end
    if (e_fall_w) begin
      oe_d = 1'b0;
      if (four_bit_q) begin
        nib_d = ~nib_q;
        if (!nib_q && !read_select_in) begin
          hi_d = host_data_pins_in[7:4];
        end
      end
    end
    if (byte_done_w && !busy_w) begin
      if (read_select_in) begin
        if (register_select_in) begin
          op_wr_d    = 1'b0;
          state_d    = ST_STEP;
          busy_cnt_d = CNT_W'(BUSY_CYCLES);
        end
      end else if (register_select_in) begin
        dr_d       = wr_byte_w;
        op_wr_d    = 1'b1;
        state_d    = ST_STEP;
        busy_cnt_d = CNT_W'(BUSY_CYCLES);
      end else begin
        cmd_d      = wr_byte_w;
        state_d    = ST_WAIT;
        busy_cnt_d = CNT_W'(BUSY_CYCLES);
        if (wr_byte_w[CMD_DDADDR_BIT]) begin
          ac_d     = wr_byte_w[6:0];
          cg_sel_d = 1'b0;
          state_d  = ST_FETCH;
        end else if (wr_byte_w[CMD_CGADDR_BIT]) begin
          ac_d     = {1'b0, wr_byte_w[5:0]};
          cg_sel_d = 1'b1;
          state_d  = ST_FETCH;
        end else if (wr_byte_w[CMD_FUNC_BIT]) begin
          four_bit_d = ~wr_byte_w[FUNC_DL_BIT];
          nib_d      = 1'b0;
          two_line_d = wr_byte_w[FUNC_N_BIT];
          font_d     = wr_byte_w[FUNC_F_BIT];
        end else if (wr_byte_w[CMD_ENTRY_BIT]) begin
          inc_d = wr_byte_w[ENTRY_ID_BIT];
        end
      end
    end
    case (state_q)
      ST_STEP: begin
        ac_d    = ac_step_w;
        state_d = op_wr_q ? ST_WAIT : ST_FETCH;
      end
      ST_FETCH: begin
        dr_d    = ram_rd_w;
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (busy_cnt_q <= CNT_W'(1)) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = state_d;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      e_q        <= 1'b0;
      oe_q       <= 1'b0;
      nib_q      <= 1'b0;
      rd_q       <= '0;
      hi_q       <= '0;
      four_bit_q <= 1'b0;
      two_line_q <= 1'b0;
      font_q     <= 1'b0;
      inc_q      <= 1'b1;
      cg_sel_q   <= 1'b0;
      op_wr_q    <= 1'b0;
      ac_q       <= '0;
      dr_q       <= '0;
      cmd_q      <= '0;
      state_q    <= ST_IDLE;
      busy_cnt_q <= '0;
      por_cnt_q  <= CNT_W'(POR_CYCLES);
    end else begin
      e_q        <= e_d;
      oe_q       <= oe_d;
      nib_q      <= nib_d;
      rd_q       <= rd_d;
      hi_q       <= hi_d;
      four_bit_q <= four_bit_d;
      two_line_q <= two_line_d;
      font_q     <= font_d;
      inc_q      <= inc_d;
      cg_sel_q   <= cg_sel_d;
      op_wr_q    <= op_wr_d;
      ac_q       <= ac_d;
      dr_q       <= dr_d;
      cmd_q      <= cmd_d;
      state_q    <= state_d;
      busy_cnt_q <= busy_cnt_d;
      por_cnt_q  <= por_cnt_d;
    end
  end

  // RAM contents are not reset; software clears the display itself
  always_ff @(posedge clk_in) begin
    if (mem_we_w) begin
      if (cg_sel_q) begin
        cg_mem[ac_q[5:0]] <= dr_q;
      end else if (dd_ok_w) begin
        dd_mem[dd_idx_w] <= dr_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign host_data_pins_out = rd_q;
  // low pins left open in 4-bit mode
  assign host_data_pins_oe_out = {{4{oe_q}}, {4{oe_q & ~four_bit_q}}};

  // ----------------------------------------------------------------
  // row pattern lookup and scan
  // ----------------------------------------------------------------
  // only pattern RAM codes render; fixed character ROM is outside
  logic [3:0]      row_w;
  logic [6:0]      line_base_w;
  logic            row_ok_w;
  logic [79:0]     row_bits_w;
  clh_duty_t       duty_w;

  assign line_base_w = (two_line_q && row_w[3]) ? LINE2_START : LINE1_START;
  assign row_ok_w    = two_line_q | ~row_w[3];
  // duty from line count and font
  assign duty_w = two_line_q ? CLH_DUTY_16
                             : (font_q ? CLH_DUTY_11 : CLH_DUTY_8);

  for (genvar k = 0; k < CHARS; k++) begin : g_char
    logic [7:0] code_w;
    assign code_w = dd_mem[line_base_w + 7'(k)];
    assign row_bits_w[k*CHAR_W +: CHAR_W] =
      (code_w[7:4] == CG_CODE_HI && row_ok_w)
        ? cg_mem[{code_w[2:0], row_w[2:0]}][CHAR_W-1:0] : '0;
  end

  clh_scan_gen #(
    .OSC_DIVIDE (OSC_DIVIDE)
  ) u_scan (
    .clk_in              (clk_in),
    .rst_n_in            (rst_n_in),
    .resistor_fitted_in  (resistor_fitted_in),
    .oscillator_input_in (oscillator_input_in),
    .duty_in             (duty_w),
    .seg_row_in          (row_bits_w[39:0]),
    .ext_row_in          (row_bits_w[79:40]),
    .row_out             (row_w),
    .segment_out         (segment_out),
    .common_out          (common_out),
    .ext_latch_clock_out (ext_latch_clock_out),
    .ext_shift_clock_out (ext_shift_clock_out),
    .alt_signal_out      (alt_signal_out),
    .ext_data_out        (ext_data_out)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_read_accept;
    byte_done_w && read_select_in && register_select_in && !busy_w;
  endsequence
  sequence s_write_accept;
    byte_done_w && !read_select_in && register_select_in && !busy_w;
  endsequence

  chk_drive_on_read:
    assert property ($rose(oe_q) |-> $past(read_select_in && e_rise_w))
    else $error("pins driven without a read strobe");
  chk_low_pins_open:
    assert property (four_bit_q |-> host_data_pins_oe_out[3:0] == 4'h0)
    else $error("low pins driven in 4-bit mode");
  chk_busy_msb:
    assert property ($rose(oe_q) && !$past(register_select_in) && !four_bit_q
                     |-> host_data_pins_out[7] == $past(busy_w))
    else $error("busy not on top pin");
  chk_status_counter:
    assert property ($rose(oe_q) && !$past(register_select_in) && !four_bit_q
                     |-> host_data_pins_out[6:0] == $past(ac_q))
    else $error("status read lacks address counter");
  chk_prefetch_seq:
    assert property (s_read_accept |=> state_q == ST_STEP
                     ##1 state_q == ST_FETCH ##1 state_q == ST_WAIT)
    else $error("no prefetch after data read");
  chk_write_back:
    assert property (s_write_accept |=> mem_we_w ##1 state_q == ST_WAIT)
    else $error("data write not stored");
  chk_refuse_busy:
    assert property (byte_done_w && !read_select_in && busy_w
                     |=> cmd_q == $past(cmd_q) && state_q != ST_STEP)
    else $error("command taken while busy");
  chk_width_select:
    assert property (byte_done_w && !busy_w && !read_select_in
                     && !register_select_in && !four_bit_q
                     && host_data_pins_in[7:5] == 3'b001
                     |=> four_bit_q == !$past(host_data_pins_in[4]))
    else $error("bus width not taken from command");
  chk_high_first:
    assert property (e_fall_w && four_bit_q && !nib_q && !read_select_in
                     |=> nib_q && hi_q == $past(host_data_pins_in[7:4]))
    else $error("high half not taken first");
endmodule

/* verification/clh_host_model.sv */
// host processor model: byte and nibble cycles on the display host port
// assumes pins_in carries the resolved pin level
`timescale 1ns/100ps
module clh_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] pins_in,
  output logic            strobe_out,
  output logic            select_out,
  output logic            read_out,
  output logic [7:0]      drive_out
);
  initial begin
    strobe_out = 1'b0;
    select_out = 1'b0;
    read_out   = 1'b0;
    drive_out  = 8'h00;
  end
  // request held until the strobe fall is seen
  task automatic cyc(input logic rs, input logic rd, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_in);
    select_out <= rs;
    read_out   <= rd;
    drive_out  <= rd ? ~drive_out : d;
    strobe_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    q = pins_in;
    strobe_out <= 1'b0;
    @(posedge clk_in);
    // released lines show the inverse, not a stale value
    drive_out  <= ~drive_out;
  endtask
  // two strobes per byte in 4-bit mode, high half first
  task automatic xfer(input logic rs, input logic rd, input logic nib,
                      input logic [7:0] d, output logic [7:0] q);
    logic [7:0] h;
    logic [7:0] l;
    if (nib) begin
      cyc(rs, rd, {d[7:4], 4'h0}, h);
      cyc(rs, rd, {d[3:0], 4'h0}, l);
      q = {h[7:4], l[7:4]};
    end else begin
      cyc(rs, rd, d, q);
    end
  endtask
  // status polled until busy reads low, at most 40 reads
  task automatic poll(input logic nib, output logic [7:0] st);
    st = 8'h80;
    for (int i = 0; i < 40 && st[7] !== 1'b0; i++) begin
      xfer(1'b0, 1'b1, nib, 8'h00, st);
    end
  endtask
endmodule

/* verification/clh_host_if_tb.sv */
// self-checking bench for the character display host port
// assumes the host model drives the strobe, select and direction pins
`timescale 1ns/100ps
module clh_host_if_tb;
  import clh_pkg::*;
  logic        clk_in, rst_n_in, fit, osc, stb, rs, rd, nib_on;
  logic        lat, shf, alt, dat;
  logic [7:0]  hdrv, pins, dout, doe, q;
  logic [3:0]  low_oe;
  logic [39:0] seg;
  logic [15:0] com;
  int          fails, compares;
  assign pins = (doe & dout) | (~doe & hdrv);
  clh_host_model h (.clk_in(clk_in), .pins_in(pins), .strobe_out(stb),
    .select_out(rs), .read_out(rd), .drive_out(hdrv));
  clh_host_if #(.BUSY_CYCLES(12), .POR_CYCLES(8), .OSC_DIVIDE(2)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .enable_strobe_in(stb),
    .register_select_in(rs), .read_select_in(rd),
    .host_data_pins_in(pins), .host_data_pins_out(dout),
    .host_data_pins_oe_out(doe), .resistor_fitted_in(fit),
    .oscillator_input_in(osc), .segment_out(seg), .common_out(com),
    .ext_latch_clock_out(lat), .ext_shift_clock_out(shf),
    .alt_signal_out(alt), .ext_data_out(dat));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    osc    <= ~osc;
    low_oe <= nib_on ? (low_oe | doe[3:0]) : 4'h0;
  end
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic put(input logic r, input logic [7:0] d, input logic n);
    h.xfer(r, 1'b0, n, d, q);
    h.poll(n, q);
    chk("ready", 16'h0000, {8'h00, q & 8'h80});
  endtask
  task automatic get(input logic [7:0] e, input logic n, input string s);
    h.xfer(1'b1, 1'b1, n, 8'h00, q);
    chk(s, {8'h00, e}, {8'h00, q});
    h.poll(n, q);
    chk("ready", 16'h0000, {8'h00, q & 8'h80});
  endtask
  task automatic t_power();
    chk("oe idle", 16'h0000, {8'h00, doe});
    h.xfer(1'b0, 1'b1, 1'b0, 8'h00, q);
    chk("busy at power-up", 16'h0080, {8'h00, q & 8'h80});
    h.poll(1'b0, q);
    chk("status ready", 16'h0000, {8'h00, q});
  endtask
  task automatic t_data();
    put(1'b0, 8'h80, 1'b0);
    put(1'b1, 8'h41, 1'b0);
    put(1'b1, 8'h42, 1'b0);
    chk("counter", 16'h0002, {8'h00, q});
    put(1'b0, 8'h85, 1'b0);
    chk("command hidden", 16'h0005, {8'h00, q});
    put(1'b0, 8'h80, 1'b0);
    get(8'h41, 1'b0, "first byte");
    get(8'h42, 1'b0, "prefetched byte");
    put(1'b0, 8'h40, 1'b0);
    put(1'b1, 8'h1f, 1'b0);
    put(1'b0, 8'h80, 1'b0);
    get(8'h41, 1'b0, "display kept");
    put(1'b0, 8'h40, 1'b0);
    get(8'h1f, 1'b0, "pattern byte");
  endtask
  task automatic t_refuse();
    put(1'b0, 8'h90, 1'b0);
    h.xfer(1'b1, 1'b0, 1'b0, 8'h11, q);
    h.xfer(1'b1, 1'b0, 1'b0, 8'h22, q);
    h.poll(1'b0, q);
    chk("one step only", 16'h0011, {8'h00, q});
    put(1'b0, 8'h90, 1'b0);
    get(8'h11, 1'b0, "kept byte");
  endtask
  task automatic t_nibble();
    h.xfer(1'b0, 1'b0, 1'b0, 8'h20, q);
    nib_on <= 1'b1;
    h.poll(1'b1, q);
    put(1'b0, 8'h83, 1'b1);
    put(1'b1, 8'ha5, 1'b1);
    put(1'b0, 8'h83, 1'b1);
    get(8'ha5, 1'b1, "nibble byte");
    chk("low pins idle", 16'h0000, {12'h000, low_oe});
    h.xfer(1'b0, 1'b0, 1'b1, 8'h30, q);
    nib_on <= 1'b0;
    h.poll(1'b0, q);
    chk("back to 8-bit", 16'h0004, {8'h00, q});
  endtask
  // pattern 0 lights row 0 only; one code in each half, rest blank
  task automatic t_ext();
    put(1'b0, 8'h40, 1'b0);
    for (int i = 0; i < 8; i++) begin
      put(1'b1, (i == 0) ? 8'h1f : 8'h00, 1'b0);
    end
    put(1'b0, 8'h80, 1'b0);
    for (int i = 0; i < 16; i++) begin
      put(1'b1, (i % 8 == 0) ? 8'h00 : 8'h20, 1'b0);
    end
    put(1'b0, 8'ha8, 1'b0);
    for (int i = 0; i < 16; i++) begin
      put(1'b1, 8'h20, 1'b0);
    end
  endtask
  task automatic t_scan(input logic r, input logic [15:0] e);
    int         l;
    int         a;
    logic       p;
    logic       pl;
    logic [15:0] m;
    int          o;
    int          n;
    int          b;
    logic        ps;
    logic [39:0] sm;
    fit <= r;
    l = 0;
    a = 0;
    p = alt;
    pl = lat;
    m = 16'h0000;
    o = 0;
    n = 0;
    b = 0;
    ps = shf;
    sm = '0;
    repeat (4000) begin
      @(posedge clk_in);
      l += (lat && !pl) ? 1 : 0;
      if (shf && !ps) begin
        o += (dat === 1'b1) ? 1 : 0;
        b += (dat !== 1'b0 && dat !== 1'b1) ? 1 : 0;
      end
      // first row is partial, so only whole rows are judged
      if (lat && !pl && l > 1) begin
        n += (o == 5) ? 1 : 0;
        b += (o != 0 && o != 5) ? 1 : 0;
        sm = sm | seg;
      end
      o = (lat && !pl) ? 0 : o;
      ps = shf;
      a += (alt !== p) ? 1 : 0;
      p = alt;
      pl = lat;
      m = m | com;
    end
    chk("latch pulses", 16'h0001, {15'h0000, l > 8});
    chk("polarity flips", 16'h0001, {15'h0000, a > 0});
    chk("one common", 16'h0001, 16'($countones(com)));
    chk("commons used", e, m);
    chk("ext rows lit", 16'h0001, {15'h0000, n > 0});
    chk("ext dot count", 16'h0000, 16'(b));
    chk("segments lit", 16'h001f, {|sm[39:15], sm[14:0]});
  endtask
  task automatic complete_run();
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #(40 * 60000);
    fails++;
    complete_run();
  end
  initial begin
    rst_n_in = 1'b0;
    fit      = 1'b1;
    osc      = 1'b0;
    nib_on   = 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_power();
    t_data();
    t_refuse();
    t_nibble();
    t_ext();
    t_scan(1'b1, 16'h00ff);
    put(1'b0, 8'h34, 1'b0);
    t_scan(1'b1, 16'h07ff);
    put(1'b0, 8'h38, 1'b0);
    t_scan(1'b0, 16'hffff);
    complete_run();
  end
endmodule
